/* inc/nvh_cyc_if.sv */
// one pin-level access request between sequencer and pin engine
`timescale 1ns/1ps
`default_nettype none
interface nvh_cyc_if;
	logic req;
	logic is_write;
	logic [14:0] addr;
	logic [7:0] wdata;
	logic done;
	logic [7:0] rdata;
	modport ctl (output req, output is_write, output addr, output wdata,
		input done, input rdata);
	modport eng (input req, input is_write, input addr, input wdata,
		output done, output rdata);
endinterface
`default_nettype wire

/* inc/nvh_pkg.sv */
// constants, types and sequence table for the nvsram host controller
package nvh_pkg;
	localparam int CLK_NS = 5;
	localparam int ADDR_W = 15;
	localparam int DATA_W = 8;
	localparam int SEQ_LEN = 6;
	localparam int NVCNT_W = 24;
	// slowest speed grade, so any part of the family is served
	localparam int ACCESS_NS = 45;
	localparam logic [3:0] ACT_CYC = 4'((ACCESS_NS + CLK_NS - 1) / CLK_NS);
	localparam int RECALL_US = 20;
	localparam int RECALL_CYC = (RECALL_US * 1000 + CLK_NS - 1) / CLK_NS;
	localparam int STORE_MS = 10;
	localparam int STORE_CYC_DEF = (STORE_MS * 1000000 + CLK_NS - 1) / CLK_NS;
	localparam int RESTORE_US = 550;
	localparam int RESTORE_CYC_DEF = (RESTORE_US * 1000 + CLK_NS - 1) / CLK_NS;
	localparam logic [14:0] SEQ_A0 = 15'h0e38;
	localparam logic [14:0] SEQ_A1 = 15'h31c7;
	localparam logic [14:0] SEQ_A2 = 15'h03e0;
	localparam logic [14:0] SEQ_A3 = 15'h3c1f;
	localparam logic [14:0] SEQ_A4 = 15'h303f;
	localparam logic [14:0] SEQ_STORE_LAST = 15'h0fc0;
	localparam logic [14:0] SEQ_RECALL_LAST = 15'h0c63;
	localparam logic [2:0] SEQ_LAST_STEP = 3'(SEQ_LEN - 1);

	typedef enum logic [1:0] {
		OP_READ = 2'b00,
		OP_WRITE = 2'b01,
		OP_STORE = 2'b10,
		OP_RECALL = 2'b11
	} nvh_op_t;

	typedef enum logic [2:0] {
		S_POWER = 3'b000,
		S_IDLE = 3'b001,
		S_ACC = 3'b010,
		S_SEQ = 3'b011,
		S_NVWAIT = 3'b100
	} nvh_state_t;

	typedef enum logic [1:0] {
		P_IDLE = 2'b00,
		P_SETUP = 2'b01,
		P_ACT = 2'b10,
		P_HOLD = 2'b11
	} nvh_pstate_t;

	// bit 14 is driven low; the part only decodes the low 14 bits here
	function automatic logic [14:0] seq_addr(input logic [2:0] step,
			input logic recall);
		logic [14:0] a;
		a = SEQ_A0;
		case (step)
			3'd1: a = SEQ_A1;
			3'd2: a = SEQ_A2;
			3'd3: a = SEQ_A3;
			3'd4: a = SEQ_A4;
			3'd5: a = recall ? SEQ_RECALL_LAST : SEQ_STORE_LAST;
			default: a = SEQ_A0;
		endcase
		return a;
	endfunction
endpackage

/* testbench/nvh_sram_model.sv */
// behavioural nvsram partner with shadow store and recall
`timescale 1ns/1ps
`default_nettype none
module nvh_sram_model #(
	parameter int STORE_NS = 200,
	parameter int RECALL_NS = 19000,
	parameter int RESTORE_NS = 150
) (
	// memory pins
	input wire logic [14:0] address_lines,
	input wire logic chip_en_n,
	input wire logic out_en_n,
	input wire logic wr_en_n,
	input wire logic [7:0] data_in,
	output logic [7:0] dq_out,
	output logic dq_oe,
	// supply above trigger level
	input wire logic supply_ok
);
	logic [7:0] mem [32768] = '{default: 8'h00};
	logic [7:0] nv [32768] = '{default: 8'h00};
	logic [13:0] seq_a [6] = '{14'h0e38, 14'h31c7, 14'h03e0, 14'h3c1f,
		14'h303f, 14'h0fc0};
	logic busy = 1'b0;
	logic dirty = 1'b0;
	logic wr_seen = 1'b0;
	logic in_wr = 1'b0;
	int step = 0;
	wire we_act = !chip_en_n && !wr_en_n;
	wire [13:0] sa = address_lines[13:0];
	assign dq_oe = !busy && !chip_en_n && !out_en_n && wr_en_n;
	assign dq_out = mem[address_lines];
	// latch at write end
	// only a write that really began may end; reset edges are not writes
	always @(negedge we_act) begin
		if (in_wr && !busy &&
				(chip_en_n === 1'b1 || wr_en_n === 1'b1)) begin
			mem[address_lines] = data_in;
			dirty = 1'b1;
		end
		in_wr = 1'b0;
	end
	always @(posedge we_act) begin
		wr_seen = 1'b1;
		in_wr = 1'b1;
	end
	always @(posedge chip_en_n)
		if (!busy) begin
			if (step == 5 && !wr_seen && sa === 14'h0fc0) begin
				step = 0;
				if (supply_ok) begin
					busy = 1'b1;
					nv = mem;
					dirty = 1'b0;
					#STORE_NS;
					busy = 1'b0;
				end
			end else if (step == 5 && !wr_seen && sa === 14'h0c63) begin
				step = 0;
				busy = 1'b1;
				mem = '{default: 8'h00};
				#RECALL_NS;
				mem = nv;
				dirty = 1'b0;
				busy = 1'b0;
			end else if (!wr_seen && sa === seq_a[step])
				step++;
			else
				step = (!wr_seen && sa === 14'h0e38) ? 1 : 0;
			wr_seen = 1'b0;
		end
	always @(negedge supply_ok) begin
		if (dirty)
			nv = mem;
		dirty = 1'b0;
	end
	always @(posedge supply_ok) begin
		busy = 1'b1;
		#RESTORE_NS;
		mem = nv;
		busy = 1'b0;
	end
endmodule
`default_nettype wire

/* testbench/tb_top.sv */
// self-checking bench for the nvsram host controller
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	localparam logic [1:0] RD = nvh_pkg::OP_READ;
	localparam logic [1:0] WR = nvh_pkg::OP_WRITE;
	localparam logic [1:0] ST = nvh_pkg::OP_STORE;
	localparam logic [1:0] RC = nvh_pkg::OP_RECALL;
	logic sys_clk = 1'b0;
	logic resetn = 1'b0;
	logic cmd_valid = 1'b0;
	logic [1:0] cmd_op = 2'b00;
	logic [14:0] cmd_addr = 15'h0000;
	logic [7:0] cmd_wdata = 8'h00;
	logic supply_ok = 1'b1;
	logic cmd_ready, resp_valid, resp_err, chip_en_n, out_en_n, wr_en_n;
	logic dut_oe, mem_oe, e;
	logic [14:0] address_lines;
	logic [7:0] resp_rdata, dut_out, mem_out, q;
	logic [7:0] dq_last = 8'h00;
	// undriven bus shows a changing value, not a held one
	wire [7:0] dq = dut_oe ? dut_out : mem_oe ? mem_out : ~dq_last;
	int mismatches = 0;
	int cmp_count = 0;

	always #2.5 sys_clk = ~sys_clk;
	always @(posedge sys_clk)
		if (dut_oe === 1'b1 || mem_oe === 1'b1)
			dq_last <= dq;

	nvh_host #(.STORE_CYC(50), .RESTORE_CYC(40)) dut (.sys_clk(sys_clk),
		.resetn(resetn), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
		.cmd_op(cmd_op), .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata),
		.resp_valid(resp_valid), .resp_rdata(resp_rdata),
		.resp_err(resp_err), .supply_ok(supply_ok),
		.address_lines(address_lines), .chip_en_n(chip_en_n),
		.out_en_n(out_en_n), .wr_en_n(wr_en_n), .data_lines_out(dut_out),
		.data_lines_oe(dut_oe), .data_lines_in(dq));
	nvh_sram_model #(.STORE_NS(200), .RECALL_NS(19000),
		.RESTORE_NS(150)) mem_model (.address_lines(address_lines),
		.chip_en_n(chip_en_n), .out_en_n(out_en_n), .wr_en_n(wr_en_n),
		.data_in(dq), .dq_out(mem_out), .dq_oe(mem_oe),
		.supply_ok(supply_ok));

	task automatic chk8(input string name, input logic [7:0] exp,
			input logic [7:0] got);
		cmp_count++;
		if (got !== exp) begin
			mismatches++;
			$display("[ERR] %s expected %h seen %h", name, exp, got);
		end
	endtask
	task automatic chk1(input string name, input logic exp, input logic got);
		cmp_count++;
		if (got !== exp) begin
			mismatches++;
			$display("[ERR] %s expected %b seen %b", name, exp, got);
		end
	endtask
	task automatic do_cmd(input logic [1:0] op, input logic [14:0] a,
			input logic [7:0] d, input logic pwr);
		int n;
		n = 0;
		do begin
			@(negedge sys_clk);
			n++;
		end while (cmd_ready !== 1'b1 && n < 9000);
		cmd_op = op;
		cmd_addr = a;
		cmd_wdata = d;
		supply_ok = pwr;
		cmd_valid = 1'b1;
		@(negedge sys_clk);
		cmd_valid = 1'b0;
		n = 0;
		while (resp_valid !== 1'b1 && n < 9000) begin
			@(negedge sys_clk);
			n++;
		end
		q = resp_rdata;
		e = resp_err;
		chk1("resp_valid", 1'b1, resp_valid);
	endtask

	task automatic t_rw;
		do_cmd(WR, 15'h7fff, 8'ha5, 1'b1);
		do_cmd(WR, 15'h0000, 8'h3c, 1'b1);
		do_cmd(RD, 15'h7fff, 8'h00, 1'b1);
		chk8("rd 7fff", 8'ha5, q);
		do_cmd(RD, 15'h0000, 8'h00, 1'b1);
		chk8("rd 0000", 8'h3c, q);
		do_cmd(RD, 15'h3fff, 8'h00, 1'b1);
		chk8("rd 3fff", 8'h00, q);
		chk1("rd err", 1'b0, e);
	endtask
	task automatic t_sw;
		do_cmd(WR, 15'h0100, 8'h11, 1'b1);
		do_cmd(ST, 15'h0000, 8'h00, 1'b1);
		chk1("store err", 1'b0, e);
		do_cmd(WR, 15'h0100, 8'h22, 1'b1);
		do_cmd(RD, 15'h0100, 8'h00, 1'b1);
		chk8("rd new", 8'h22, q);
		do_cmd(RC, 15'h0000, 8'h00, 1'b1);
		chk1("recall err", 1'b0, e);
		do_cmd(RD, 15'h0100, 8'h00, 1'b1);
		chk8("rd recalled", 8'h11, q);
	endtask
	task automatic t_power;
		do_cmd(WR, 15'h0200, 8'h77, 1'b1);
		do_cmd(ST, 15'h0000, 8'h00, 1'b0);
		chk1("low store err", 1'b1, e);
		supply_ok = 1'b1;
		do_cmd(RD, 15'h0200, 8'h00, 1'b1);
		chk8("rd after power", 8'h77, q);
		do_cmd(RD, 15'h0100, 8'h00, 1'b1);
		chk8("rd kept", 8'h11, q);
	endtask
	task automatic t_cut;
		fork
			do_cmd(RD, 15'h0100, 8'h00, 1'b1);
			begin
				repeat (6) @(negedge sys_clk);
				supply_ok = 1'b0;
			end
		join
		chk1("cut err", 1'b1, e);
		supply_ok = 1'b1;
		do_cmd(RD, 15'h0100, 8'h00, 1'b1);
		chk8("rd after cut", 8'h11, q);
	endtask

	task automatic results;
		$display("comparisons %0d mismatches %0d", cmp_count, mismatches);
		if (mismatches == 0 && cmp_count > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	initial begin
		repeat (5) @(posedge sys_clk);
		@(negedge sys_clk);
		resetn = 1'b1;
		t_rw;
		t_sw;
		t_power;
		t_cut;
		results;
	end
	// run needs about 25 us; eight times that is a hang
	initial begin
		#200000;
		mismatches++;
		results;
	end
endmodule
`default_nettype wire

/* verilog/nvh_host.sv */
// host controller for a 32k x 8 nonvolatile sram on its async pins
// What this block does
// - host holds address stable through write
// - host presents data before terminating edge
// - host keeps output enable high writing
// - six fixed reads start a store
// - six fixed reads start a recall
// - sequence uses enable-controlled reads only
// - host keeps write high during sequence
`timescale 1ns/1ps
`default_nettype none
module nvh_host #(
	parameter int STORE_CYC = nvh_pkg::STORE_CYC_DEF,
	parameter int RESTORE_CYC = nvh_pkg::RESTORE_CYC_DEF
) (
	// clock and reset
	input wire logic sys_clk,
	input wire logic resetn,
	// command port
	input wire logic cmd_valid,
	output logic cmd_ready,
	input wire logic [1:0] cmd_op,
	input wire logic [14:0] cmd_addr,
	input wire logic [7:0] cmd_wdata,
	// answer port
	output logic resp_valid,
	output logic [7:0] resp_rdata,
	output logic resp_err,
	// supply monitor: high while above trigger level
	input wire logic supply_ok,
	// memory pins
	output logic [14:0] address_lines,
	output logic chip_en_n,
	output logic out_en_n,
	output logic wr_en_n,
	output logic [7:0] data_lines_out,
	output logic data_lines_oe,
	input wire logic [7:0] data_lines_in
);
	nvh_pkg::nvh_state_t state;
	logic [2:0] step;
	logic [23:0] cnt;
	logic pend;
	logic recall;
	logic acc_wr;
	logic [14:0] acc_addr;
	logic [7:0] acc_wdata;
	logic pin_busy;

	nvh_cyc_if cyc ();

	wire take = cmd_valid && cmd_ready;
	wire op_nv = cmd_op[1];
	wire in_acc = (state == nvh_pkg::S_ACC);
	wire in_seq = (state == nvh_pkg::S_SEQ);
	wire seq_end = in_seq && cyc.done && (step == nvh_pkg::SEQ_LAST_STEP);
	wire wait_end = (state == nvh_pkg::S_NVWAIT) && (cnt == 24'h00_0001);
	wire owes_answer = in_acc || in_seq || pend;
	wire [23:0] nv_cnt = recall ? 24'(nvh_pkg::RECALL_CYC) : 24'(STORE_CYC);

	assign cmd_ready = (state == nvh_pkg::S_IDLE);
	// no foreign access can split the six reads
	assign cyc.req = in_acc || in_seq;
	assign cyc.is_write = in_acc && acc_wr;
	assign cyc.addr = in_seq ? nvh_pkg::seq_addr(step, recall) : acc_addr;
	assign cyc.wdata = acc_wdata;

	nvh_pin_cycle u_pins (
		.sys_clk(sys_clk),
		.resetn(resetn),
		.cyc(cyc.eng),
		.address_lines(address_lines),
		.chip_en_n(chip_en_n),
		.out_en_n(out_en_n),
		.wr_en_n(wr_en_n),
		.data_lines_out(data_lines_out),
		.data_lines_oe(data_lines_oe),
		.data_lines_in(data_lines_in)
	);

	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			state <= nvh_pkg::S_POWER;
			step <= 3'd0;
			cnt <= 24'h00_0000;
			pend <= 1'b0;
			recall <= 1'b0;
			acc_wr <= 1'b0;
			acc_addr <= 15'h0000;
			acc_wdata <= 8'h00;
			resp_valid <= 1'b0;
			resp_rdata <= 8'h00;
			resp_err <= 1'b0;
			pin_busy <= 1'b0;
		end else begin
			resp_valid <= 1'b0;
			resp_err <= 1'b0;
			// mirrors the pin engine leaving and reaching idle, so a
			// cut access is let finish before the power-up wait
			if (cyc.done)
				pin_busy <= 1'b0;
			else if (cyc.req)
				pin_busy <= 1'b1;
			if (!supply_ok) begin
				// no store below trigger level; also fails
				// anything in flight, the part is going down
				resp_valid <= take || owes_answer;
				resp_err <= take || owes_answer;
				pend <= 1'b0;
				state <= nvh_pkg::S_POWER;
			end else begin
				unique case (state)
					nvh_pkg::S_POWER: if (!pin_busy) begin
						// part recalls on its own at power-up
						// wait counted only once the pins are quiet
						cnt <= 24'(RESTORE_CYC);
						state <= nvh_pkg::S_NVWAIT;
					end
					nvh_pkg::S_IDLE: if (take) begin
						acc_wr <= (cmd_op == nvh_pkg::OP_WRITE);
						acc_addr <= cmd_addr;
						acc_wdata <= cmd_wdata;
						recall <= (cmd_op == nvh_pkg::OP_RECALL);
						step <= 3'd0;
						state <= op_nv ? nvh_pkg::S_SEQ : nvh_pkg::S_ACC;
					end
					nvh_pkg::S_ACC: if (cyc.done) begin
						resp_valid <= 1'b1;
						resp_rdata <= acc_wr ? 8'h00 : cyc.rdata;
						state <= nvh_pkg::S_IDLE;
					end
					nvh_pkg::S_SEQ: if (cyc.done) begin
						step <= step + 3'd1;
						if (seq_end) begin
							pend <= 1'b1;
							cnt <= nv_cnt;
							state <= nvh_pkg::S_NVWAIT;
						end
					end
					nvh_pkg::S_NVWAIT: begin
						// pins stay idle for the whole duration
						cnt <= cnt - 24'h00_0001;
						if (wait_end) begin
							resp_valid <= pend;
							pend <= 1'b0;
							state <= nvh_pkg::S_IDLE;
						end
					end
					default: state <= nvh_pkg::S_POWER;
				endcase
			end
		end
	end

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!resetn);

	sequence seq_begin;
		$rose(in_seq);
	endsequence
	property first_step_addr;
		seq_begin |-> cyc.addr == nvh_pkg::SEQ_A0;
	endproperty

	chk_nv_quiet: assert property (
		(state == nvh_pkg::S_NVWAIT) |-> !cyc.req && chip_en_n)
		else $error("pin access during nonvolatile wait");
	chk_store_inhibit: assert property (
		(take && !supply_ok) |=> resp_valid && resp_err)
		else $error("command at low supply not refused");
	chk_seq_first_addr: assert property (first_step_addr)
		else $error("sequence does not open at first address");
	chk_six_then_wait: assert property (
		(seq_end && supply_ok) |=> state == nvh_pkg::S_NVWAIT && pend)
		else $error("sixth read did not start wait");
	chk_seq_top_bit: assert property (in_seq |-> !cyc.addr[14])
		else $error("sequence drives top address bit");

	sequence step_open;
		in_seq && $fell(chip_en_n);
	endsequence
	sequence last_step_open;
		step_open ##0 (step == nvh_pkg::SEQ_LAST_STEP);
	endsequence

	chk_seq_pin_first: assert property (
		step_open ##0 (step == 3'd0) |-> address_lines == nvh_pkg::SEQ_A0)
		else $error("first sequence read at wrong address");
	chk_seq_mid_addr: assert property (
		step_open ##0 (step == 3'd4) |-> address_lines == nvh_pkg::SEQ_A4)
		else $error("fifth sequence read at wrong address");
	chk_store_last_addr: assert property (
		last_step_open ##0 !recall |->
		address_lines == nvh_pkg::SEQ_STORE_LAST)
		else $error("store sequence ends at wrong address");
	chk_recall_last_addr: assert property (
		last_step_open ##0 recall |->
		address_lines == nvh_pkg::SEQ_RECALL_LAST)
		else $error("recall sequence ends at wrong address");
	chk_seq_we_high: assert property (in_seq |-> wr_en_n)
		else $error("write enable low inside sequence");
	chk_seq_no_gap: assert property (
		(in_seq && cyc.done && !seq_end && supply_ok) |=> in_seq)
		else $error("sequence left before sixth read");
	chk_power_pins_idle: assert property (
		(state == nvh_pkg::S_POWER && !pin_busy) |-> chip_en_n)
		else $error("pins active while power-up wait may start");
endmodule
`default_nettype wire

/* verilog/nvh_pin_cycle.sv */
// pin engine: one chip-enable controlled read or write on the sram pins
`timescale 1ns/1ps
`default_nettype none
module nvh_pin_cycle (
	// clock and reset
	input wire logic sys_clk,
	input wire logic resetn,
	// request from sequencer
	nvh_cyc_if.eng cyc,
	// memory pins
	output logic [14:0] address_lines,
	output logic chip_en_n,
	output logic out_en_n,
	output logic wr_en_n,
	output logic [7:0] data_lines_out,
	output logic data_lines_oe,
	input wire logic [7:0] data_lines_in
);
	nvh_pkg::nvh_pstate_t pstate;
	logic [3:0] cnt;
	logic [7:0] rdata;
	logic wr;
	wire act_end = (pstate == nvh_pkg::P_ACT) && (cnt == 4'h0);

	assign cyc.done = (pstate == nvh_pkg::P_HOLD);
	assign cyc.rdata = rdata;

	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			pstate <= nvh_pkg::P_IDLE;
			cnt <= 4'h0;
			rdata <= 8'h00;
			wr <= 1'b0;
			address_lines <= 15'h0000;
			chip_en_n <= 1'b1;
			out_en_n <= 1'b1;
			wr_en_n <= 1'b1;
			data_lines_out <= 8'h00;
			data_lines_oe <= 1'b0;
		end else begin
			unique case (pstate)
				nvh_pkg::P_IDLE: if (cyc.req) begin
					address_lines <= cyc.addr;
					data_lines_out <= cyc.wdata;
					data_lines_oe <= cyc.is_write;
					wr <= cyc.is_write;
					pstate <= nvh_pkg::P_SETUP;
				end
				nvh_pkg::P_SETUP: begin
					chip_en_n <= 1'b0;
					out_en_n <= wr;
					wr_en_n <= !wr;
					cnt <= nvh_pkg::ACT_CYC - 4'h1;
					pstate <= nvh_pkg::P_ACT;
				end
				nvh_pkg::P_ACT: begin
					cnt <= cnt - 4'h1;
					if (act_end) begin
						if (!wr)
							rdata <= data_lines_in;
						chip_en_n <= 1'b1;
						out_en_n <= 1'b1;
						wr_en_n <= 1'b1;
						pstate <= nvh_pkg::P_HOLD;
					end
				end
				nvh_pkg::P_HOLD: begin
					data_lines_oe <= 1'b0;
					pstate <= nvh_pkg::P_IDLE;
				end
			endcase
		end
	end

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!resetn);

	sequence enable_fall;
		$fell(chip_en_n);
	endsequence
	sequence enable_held;
		(!chip_en_n)[*8];
	endsequence

	chk_write_oe_high: assert property (!wr_en_n |-> out_en_n)
		else $error("output enable low during write");
	chk_address_stable: assert property (
		(!chip_en_n || $past(!chip_en_n)) |-> $stable(address_lines))
		else $error("address moved during access");
	chk_write_data_driven: assert property (
		(!wr_en_n || $rose(wr_en_n)) |-> data_lines_oe)
		else $error("write data not driven to end of write");
	chk_read_we_high: assert property (!out_en_n |-> wr_en_n)
		else $error("write enable low during read");
	chk_strobe_width: assert property (
		enable_fall |=> enable_held ##1 chip_en_n)
		else $error("chip enable pulse not nine cycles");
endmodule
`default_nettype wire
